// file: logic/opdp_regs.svh
// Register map, field positions and limits of the operand-type datapath
// Summary of operation
// - Word type is unsigned 16 bits in one register, 0 to 65,535.
// - Integer type is signed 16 bits in one register, -32,768 to 32,767.
// - Double-word type is unsigned 32 bits across two registers.
// - Long type is signed 32 bits across two registers.
// - Only typed instruction groups honour the type; all others work on 16-bit words.
// - Addition beyond range keeps the low bits and raises the carry indication; signed types here keep the true sign over the low bits instead.
// - Subtraction below range keeps low bits and raises borrow; in-range raises neither. Signed types here keep the true sign over the low bits instead.
// - Float type is IEEE-754 single precision held in two consecutive registers.
// - Float fraction bits 0-22, exponent bits 23-30, sign bit 31.
// - Exponent strictly between 0 and 255 is a normal number.
// - Zero exponent with zero fraction is a signed zero.
// - Invalid float operand or result raises the execution error and fault lamp.
// - Float instructions update carry/borrow: overflow, underflow set it; exact zero clears. Float add/sub here raise the execution error instead.
// - By default the first register holds the high word, the next the low word.
// - A setting reverses the high/low word order of two-register operands.
// - Device areas never continue into each other; operands stay in one area.
// - No-operation changes nothing and needs no condition or operand.
// - Execute while the condition is true; otherwise skip and hold all devices.
// - An execution error suppresses the write-back to the destination.
`ifndef OPDP_REGS_SVH
`define OPDP_REGS_SVH

// ***************
// Byte offsets
// ***************
`define OFF_CTRL 8'h00
`define OFF_A_FIRST 8'h04
`define OFF_A_NEXT 8'h08
`define OFF_B_FIRST 8'h0C
`define OFF_B_NEXT 8'h10
`define OFF_D_FIRST 8'h14
`define OFF_D_NEXT 8'h18
`define OFF_STATUS 8'h1C
`define OFF_DST_IDX 8'h20

// ***************
// Fields
// ***************
`define CTRL_GO 0
`define CTRL_COND 1
`define CTRL_OP_LSB 2
`define CTRL_OP_W 3
`define CTRL_DT_LSB 5
`define CTRL_DT_W 3
`define CTRL_SWAP 8
`define CTRL_RST 16'h0000
`define ST_CB 0
`define ST_ERR 1
`define ST_CY 2
`define ST_BW 3
`define ST_BUSY 4
`define FP_FRAC_MSB 22
`define FP_EXP_LSB 23
`define FP_EXP_MSB 30
`define FP_EXP_ZERO 8'h00
`define FP_EXP_MAX 8'hFF

// ***************
// Device areas (inclusive ends) and bus answers
// ***************
`define AREA0_END 15'h07CF
`define AREA1_END 15'h1F3F
`define AREA2_END 15'h2007
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: logic/opdp_pkg.sv
// Types shared by the operand-type datapath modules
package opdp_pkg;

   typedef enum logic [2:0] {DT_W = 3'h0, DT_I = 3'h1, DT_D = 3'h2, DT_L = 3'h3,
      DT_F = 3'h4} dtype_t;

   typedef enum logic [2:0] {OP_NOP = 3'h0, OP_MOV = 3'h1, OP_ADD = 3'h2, OP_SUB = 3'h3,
      OP_INC = 3'h4} op_t;

   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_EXEC = 2'b10} st_t;

   typedef struct packed {
      st_t st;
      logic aw_ok;
      logic [7:0] aw_addr;
      logic w_ok;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [15:0] ctrl;
      logic [15:0] a_first;
      logic [15:0] a_next;
      logic [15:0] b_first;
      logic [15:0] b_next;
      logic [15:0] d_first;
      logic [15:0] d_next;
      logic [14:0] dst_idx;
      logic cb;
      logic err;
      logic cy;
      logic bw;
   } regs_t;

endpackage : opdp_pkg

// file: logic/fp_chk_if.sv
// Carrier between the datapath and its float pattern classifier
`timescale 1ns/1ps
interface fp_chk_if;
   logic [31:0] word;
   logic is_zero;
   logic is_normal;
   logic invalid;
   modport cls (input word, output is_zero, output is_normal, output invalid);
   modport user (output word, input is_zero, input is_normal, input invalid);
endinterface : fp_chk_if

// file: logic/fp_classify.sv
// Single-precision float pattern classifier
`timescale 1ns/1ps
`include "opdp_regs.svh"
module fp_classify
(
   // Pattern in, class out
   fp_chk_if.cls chk
);
   import opdp_pkg::*;

   logic [7:0] expo;
   logic [22:0] frac;

   assign expo = chk.word[`FP_EXP_MSB:`FP_EXP_LSB];
   assign frac = chk.word[`FP_FRAC_MSB:0];
   assign chk.is_zero = (expo == `FP_EXP_ZERO) && (frac == '0);
   assign chk.is_normal = (expo != `FP_EXP_ZERO) && (expo != `FP_EXP_MAX);
   // Subnormals count as invalid too: the block has no gradual underflow path
   assign chk.invalid = !chk.is_zero && !chk.is_normal;
endmodule : fp_classify

// file: logic/plc_operand_type_datapath.sv
// Operand-type datapath with AXI4-Lite register access
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "opdp_regs.svh"
module plc_operand_type_datapath
#(
   parameter int ADDR_W = 8
)
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [ADDR_W-1:0] awaddr,
   // Write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // Write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // Read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [ADDR_W-1:0] araddr,
   // Read data
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Flags
   output logic carry_borrow_relay,
   output logic exec_error_relay,
   output logic fault_lamp
);
   import opdp_pkg::*;

   // ***************
   // Helpers
   // ***************
   function automatic logic [31:0] join_w(input logic [15:0] f, input logic [15:0] n,
      input logic sw);
      join_w = sw ? {n, f} : {f, n};
   endfunction : join_w

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
      input logic [3:0] st);
      merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
   endfunction : merge16

   // Flag in bit 32, stored result below
   function automatic logic [32:0] arith(input logic [31:0] a, input logic [31:0] b,
      input logic sub, input logic wide, input logic sgn);
      logic [33:0] ea;
      logic [33:0] eb;
      logic [33:0] r;
      logic fl;
      if (wide)
      begin
         ea = sgn ? {{2{a[31]}}, a} : {2'h0, a};
         eb = sgn ? {{2{b[31]}}, b} : {2'h0, b};
      end
      else
      begin
         ea = sgn ? {{18{a[15]}}, a[15:0]} : {18'h0, a[15:0]};
         eb = sgn ? {{18{b[15]}}, b[15:0]} : {18'h0, b[15:0]};
      end
      r = sub ? ea - eb : ea + eb;
      // Signed: out of range when the two top bits differ; unsigned: bit past width
      if (sgn)
         fl = wide ? (r[32] != r[31]) : (r[16] != r[15]);
      else
         fl = wide ? r[32] : r[16];
      // Signed overflow keeps the true sign over the low bits, so a wrap never flips sign
      if (sgn)
         arith = {fl, wide ? {r[33], r[30:0]} : {16'h0, r[33], r[14:0]}};
      else
         arith = {fl, wide ? r[31:0] : {16'h0, r[15:0]}};
   endfunction : arith

   function automatic logic area_ok(input logic [14:0] idx, input logic wide);
      logic [14:0] last;
      last = idx + {14'h0, wide};
      if (idx <= `AREA0_END)
         area_ok = last <= `AREA0_END;
      else if (idx <= `AREA1_END)
         area_ok = last <= `AREA1_END;
      else if (idx <= `AREA2_END)
         area_ok = last <= `AREA2_END;
      else
         area_ok = 1'b0;
   endfunction : area_ok

   // ***************
   // State
   // ***************
   regs_t s_q;
   regs_t s_d;
   fp_chk_if fchk ();
   fp_classify u_cls (.chk(fchk.cls));

   op_t op;
   dtype_t dt;
   logic swap;
   logic wide;
   logic sgn;
   logic is_fl;
   logic [31:0] a_val;
   logic [31:0] b_val;
   logic [32:0] ar;
   logic [31:0] res;
   logic err_now;
   logic exec_go;
   logic [7:0] wa;
   logic [7:0] ra;

   assign op = op_t'(s_q.ctrl[`CTRL_OP_LSB +: `CTRL_OP_W]);
   // Non-typed groups always run as 16-bit words
   assign dt = (op == OP_INC) ? DT_W : dtype_t'(s_q.ctrl[`CTRL_DT_LSB +: `CTRL_DT_W]);
   assign swap = s_q.ctrl[`CTRL_SWAP];
   assign wide = (dt == DT_D) || (dt == DT_L) || (dt == DT_F);
   assign sgn = (dt == DT_I) || (dt == DT_L);
   assign is_fl = (dt == DT_F);
   assign a_val = wide ? join_w(s_q.a_first, s_q.a_next, swap) : {16'h0, s_q.a_first};
   assign b_val = (op == OP_INC) ? 32'h0000_0001 :
      (wide ? join_w(s_q.b_first, s_q.b_next, swap) : {16'h0, s_q.b_first});
   assign fchk.word = a_val;
   assign ar = arith(a_val, b_val, op == OP_SUB, wide, sgn);
   assign res = (op == OP_MOV) ? a_val : ar[31:0];
   // Float add/sub has no arithmetic unit here, so it is reported as an error
   assign err_now = !area_ok(s_q.dst_idx, wide) ||
      (is_fl && (fchk.invalid || (op != OP_MOV)));
   assign exec_go = (s_q.st == ST_EXEC) && s_q.ctrl[`CTRL_COND] && (op != OP_NOP);
   assign wa = {s_q.aw_addr[7:2], 2'h0};
   assign ra = {araddr[7:2], 2'h0};

   // ***************
   // Next state
   // ***************
   always_comb
   begin
      s_d = s_q;
      awready = !s_q.aw_ok && !s_q.bvalid;
      wready = !s_q.w_ok && !s_q.bvalid;
      arready = !s_q.rvalid;
      if (awvalid && awready)
      begin
         s_d.aw_ok = 1'b1;
         s_d.aw_addr = awaddr[7:0];
      end
      if (wvalid && wready)
      begin
         s_d.w_ok = 1'b1;
         s_d.w_data = wdata;
         s_d.w_strb = wstrb;
      end
      if (s_q.bvalid && bready)
         s_d.bvalid = 1'b0;
      if (s_q.st == ST_EXEC)
         s_d.st = ST_IDLE;
      // Register writes, both halves held
      if (s_q.aw_ok && s_q.w_ok)
      begin
         s_d.aw_ok = 1'b0;
         s_d.w_ok = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = `RESP_OKAY;
         if (wa == `OFF_CTRL)
         begin
            s_d.ctrl = merge16(s_q.ctrl, s_q.w_data, s_q.w_strb);
            s_d.ctrl[`CTRL_GO] = 1'b0;
            if (s_q.w_strb[0] && s_q.w_data[`CTRL_GO] && (s_q.st == ST_IDLE))
               s_d.st = ST_EXEC;
         end
         else if (wa == `OFF_A_FIRST)
            s_d.a_first = merge16(s_q.a_first, s_q.w_data, s_q.w_strb);
         else if (wa == `OFF_A_NEXT)
            s_d.a_next = merge16(s_q.a_next, s_q.w_data, s_q.w_strb);
         else if (wa == `OFF_B_FIRST)
            s_d.b_first = merge16(s_q.b_first, s_q.w_data, s_q.w_strb);
         else if (wa == `OFF_B_NEXT)
            s_d.b_next = merge16(s_q.b_next, s_q.w_data, s_q.w_strb);
         else if (wa == `OFF_DST_IDX)
            s_d.dst_idx = 15'(merge16({1'b0, s_q.dst_idx}, s_q.w_data, s_q.w_strb));
         else if (wa == `OFF_STATUS)
         begin
            if (s_q.w_strb[0] && s_q.w_data[`ST_ERR])
               s_d.err = 1'b0;
         end
         else if ((wa != `OFF_D_FIRST) && (wa != `OFF_D_NEXT))
            s_d.bresp = `RESP_SLVERR;
      end
      // Execution; placed after the clear so a new error wins over it
      if (exec_go)
      begin
         if (err_now)
            s_d.err = 1'b1;
         else
         begin
            if (wide)
            begin
               s_d.d_first = swap ? res[15:0] : res[31:16];
               s_d.d_next = swap ? res[31:16] : res[15:0];
            end
            else
               s_d.d_first = res[15:0];
            if (is_fl)
            begin
               // A copied valid pattern is zero or normal: no overflow or underflow
               s_d.cb = 1'b0;
               s_d.cy = 1'b0;
               s_d.bw = 1'b0;
            end
            else if (op != OP_MOV)
            begin
               s_d.cb = ar[32];
               s_d.cy = ar[32] && (op != OP_SUB);
               s_d.bw = ar[32] && (op == OP_SUB);
            end
         end
      end
      // Reads
      if (s_q.rvalid && rready)
         s_d.rvalid = 1'b0;
      if (arvalid && arready)
      begin
         s_d.rvalid = 1'b1;
         s_d.rresp = `RESP_OKAY;
         if (ra == `OFF_CTRL)
            s_d.rdata = {16'h0, s_q.ctrl};
         else if (ra == `OFF_A_FIRST)
            s_d.rdata = {16'h0, s_q.a_first};
         else if (ra == `OFF_A_NEXT)
            s_d.rdata = {16'h0, s_q.a_next};
         else if (ra == `OFF_B_FIRST)
            s_d.rdata = {16'h0, s_q.b_first};
         else if (ra == `OFF_B_NEXT)
            s_d.rdata = {16'h0, s_q.b_next};
         else if (ra == `OFF_D_FIRST)
            s_d.rdata = {16'h0, s_q.d_first};
         else if (ra == `OFF_D_NEXT)
            s_d.rdata = {16'h0, s_q.d_next};
         else if (ra == `OFF_DST_IDX)
            s_d.rdata = {17'h0, s_q.dst_idx};
         else if (ra == `OFF_STATUS)
            s_d.rdata = {27'h0, s_q.st == ST_EXEC, s_q.bw, s_q.cy, s_q.err, s_q.cb};
         else
         begin
            s_d.rdata = 32'h0000_0000;
            s_d.rresp = `RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_q <= '0;
         s_q.st <= ST_IDLE;
         s_q.ctrl <= `CTRL_RST;
      end
      else
         s_q <= s_d;
   end

   // ***************
   // Outputs
   // ***************
   assign bvalid = s_q.bvalid;
   assign bresp = s_q.bresp;
   assign rvalid = s_q.rvalid;
   assign rdata = s_q.rdata;
   assign rresp = s_q.rresp;
   assign carry_borrow_relay = s_q.cb;
   assign exec_error_relay = s_q.err;
   assign fault_lamp = s_q.err;

   // ***************
   // Checks
   // ***************
   default clocking cb_clk @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_wr_taken;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence s_wr_answer;
      ##[1:2] bvalid;
   endsequence

   a_write_answer: assert property (s_wr_taken |-> s_wr_answer)
      else $error("write not answered in time");
   a_err_no_wb: assert property (exec_go && err_now |=> $stable(s_q.d_first) && $stable(s_q.d_next) && s_q.err)
      else $error("destination changed on error");
   a_cond_off_hold: assert property ((s_q.st == ST_EXEC) && !s_q.ctrl[`CTRL_COND] |=> $stable(s_q.d_first) && $stable(s_q.cb))
      else $error("skipped instruction changed a device");
   a_nop_hold: assert property ((s_q.st == ST_EXEC) && (op == OP_NOP) |=> $stable(s_q.d_first) && $stable(s_q.d_next) && $stable(s_q.cb))
      else $error("no-operation changed a device");
   a_word_add_wrap: assert property (exec_go && !err_now && (op == OP_ADD) && (dt == DT_W) |=> (s_q.d_first == $past(s_q.a_first + s_q.b_first)) && (s_q.cy == ($past(s_q.a_first) > ~$past(s_q.b_first))))
      else $error("word add wrap or carry wrong");
   a_word_sub_borrow: assert property (exec_go && !err_now && (op == OP_SUB) && (dt == DT_W) |=> s_q.bw == ($past(s_q.a_first) < $past(s_q.b_first)))
      else $error("word subtract borrow wrong");
   a_int_pos_wrap: assert property (exec_go && !err_now && (dt == DT_I) &&
      (op == OP_ADD) && !s_q.a_first[15] && !s_q.b_first[15] |=> !s_q.d_first[15])
      else $error("positive integer sum changed sign");
   a_fp_invalid_err: assert property (exec_go && is_fl && fchk.invalid |=> s_q.err && fault_lamp)
      else $error("invalid float not flagged");
   a_fp_zero_flag: assert property (exec_go && is_fl && (op == OP_MOV) && fchk.is_zero && !err_now |=> !s_q.cb)
      else $error("float zero left carry set");
   a_area_err: assert property (exec_go && wide && !area_ok(s_q.dst_idx, wide) |=> s_q.err)
      else $error("area overrun not flagged");
   a_high_first: assert property (exec_go && !err_now && (op == OP_MOV) && (dt == DT_D) && !swap |=> (s_q.d_first == $past(s_q.a_first)) && (s_q.d_next == $past(s_q.a_next)))
      else $error("default word order wrong");
   a_swap_order: assert property (exec_go && !err_now && (op == OP_MOV) && (dt == DT_L) && swap |=> (s_q.d_first == $past(s_q.a_first)) && (s_q.d_next == $past(s_q.a_next)))
      else $error("reversed word order wrong");
   a_inc_word_only: assert property (exec_go && !err_now && (op == OP_INC) |=> $stable(s_q.d_next))
      else $error("untyped instruction touched second word");

endmodule : plc_operand_type_datapath

// file: tb/plc_operand_type_datapath_tb.sv
// Self-checking bench for the operand-type datapath over its register bus
`timescale 1ns/1ps
`include "opdp_regs.svh"
module plc_operand_type_datapath_tb;
   import opdp_pkg::*;
   // ***************
   // Signals
   // ***************
   logic aclk, aresetn;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic carry_borrow_relay, exec_error_relay, fault_lamp;
   int num_errors = 0;
   int n_checks = 0;

   plc_operand_type_datapath #(.ADDR_W(8)) u_dut (.aclk(aclk), .aresetn(aresetn),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
      .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
      .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .carry_borrow_relay(carry_borrow_relay), .exec_error_relay(exec_error_relay),
      .fault_lamp(fault_lamp));

   initial
   begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   // ***************
   // Checking and bus tasks
   // ***************
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic tally_and_finish();
      if (num_errors == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : tally_and_finish

   // Valid and payload held until each channel's own handshake edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_t, w_t, b_t;
      logic [1:0] resp;
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      wstrb <= 4'hF;
      bready <= 1'b1;
      b_t = 1'b0;
      while (!b_t)
      begin
         @(posedge aclk);
         aw_t = awvalid && awready;
         w_t = wvalid && wready;
         b_t = bvalid && bready;
         resp = bresp;
         if (aw_t)
            awvalid <= 1'b0;
         if (w_t)
            wvalid <= 1'b0;
         if (b_t)
            bready <= 1'b0;
      end
      check({30'h0, resp}, {30'h0, er});
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
      input logic [1:0] er);
      logic ar_t, r_t;
      logic [31:0] d;
      logic [1:0] resp;
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      r_t = 1'b0;
      while (!r_t)
      begin
         @(posedge aclk);
         ar_t = arvalid && arready;
         r_t = rvalid && rready;
         d = rdata;
         resp = rresp;
         if (ar_t)
            arvalid <= 1'b0;
         if (r_t)
            rready <= 1'b0;
      end
      check(d & m, e);
      check({30'h0, resp}, {30'h0, er});
   endtask : rd

   task automatic ld(input logic [15:0] a1, a2, b1, b2);
      wr(`OFF_A_FIRST, {16'h0, a1}, `RESP_OKAY);
      wr(`OFF_A_NEXT, {16'h0, a2}, `RESP_OKAY);
      wr(`OFF_B_FIRST, {16'h0, b1}, `RESP_OKAY);
      wr(`OFF_B_NEXT, {16'h0, b2}, `RESP_OKAY);
   endtask : ld

   task automatic go(input op_t op, input dtype_t dt, input logic sw, input logic cond);
      wr(`OFF_CTRL, {23'h0, sw, dt, op, cond, 1'b1}, `RESP_OKAY);
   endtask : go

   // Result pair and all four status flags in one step
   task automatic res(input logic [15:0] f, input logic [15:0] n, input logic [3:0] fl);
      rd(`OFF_D_FIRST, 32'hFFFF, {16'h0, f}, `RESP_OKAY);
      rd(`OFF_D_NEXT, 32'hFFFF, {16'h0, n}, `RESP_OKAY);
      rd(`OFF_STATUS, 32'h000F, {28'h0, fl}, `RESP_OKAY);
   endtask : res

   task automatic err_seen();
      check({31'h0, exec_error_relay}, 32'h1);
      check({31'h0, fault_lamp}, 32'h1);
      wr(`OFF_STATUS, 32'h0000_0002, `RESP_OKAY);
      check({31'h0, exec_error_relay}, 32'h0);
   endtask : err_seen

   // ***************
   // Watchdog
   // ***************
   initial
   begin
      repeat (20000) @(posedge aclk);
      num_errors++;
      tally_and_finish();
   end

   // ***************
   // Tests
   // ***************
   logic [31:0] bad_fp [2] = '{32'h7F80_0000, 32'h0000_0001};
   initial
   begin
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = '0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      check({29'h0, carry_borrow_relay, exec_error_relay, fault_lamp}, 32'h0);
      rd(`OFF_CTRL, 32'hFFFF, 32'h0, `RESP_OKAY);
      rd(`OFF_STATUS, 32'h001F, 32'h0, `RESP_OKAY);
      ld(16'hFFFF, 16'h0, 16'hFFFF, 16'h0);
      go(OP_ADD, DT_W, 1'b0, 1'b1);
      res(16'hFFFE, 16'h0000, 4'h5);
      ld(16'h0000, 16'h0, 16'h0001, 16'h0);
      go(OP_SUB, DT_W, 1'b0, 1'b1);
      res(16'hFFFF, 16'h0000, 4'h9);
      ld(16'h0005, 16'h0, 16'h0003, 16'h0);
      go(OP_SUB, DT_W, 1'b0, 1'b1);
      res(16'h0002, 16'h0000, 4'h0);
      ld(16'h7FFF, 16'h0, 16'h0001, 16'h0);
      go(OP_ADD, DT_I, 1'b0, 1'b1);
      res(16'h0000, 16'h0000, 4'h5);
      ld(16'hFFFF, 16'hFFFF, 16'h0000, 16'h0001);
      go(OP_ADD, DT_D, 1'b0, 1'b1);
      res(16'h0000, 16'h0000, 4'h5);
      // Swapped order: first register carries the low word
      ld(16'h0000, 16'h8000, 16'h0001, 16'h0000);
      go(OP_SUB, DT_L, 1'b1, 1'b1);
      res(16'hFFFF, 16'hFFFF, 4'h9);
      ld(16'h1234, 16'h0, 16'h0001, 16'h0);
      go(OP_ADD, DT_W, 1'b0, 1'b0);
      res(16'hFFFF, 16'hFFFF, 4'h9);
      go(OP_NOP, DT_W, 1'b0, 1'b1);
      res(16'hFFFF, 16'hFFFF, 4'h9);
      go(OP_INC, DT_D, 1'b0, 1'b1);
      rd(`OFF_D_FIRST, 32'hFFFF, 32'h1235, `RESP_OKAY);
      rd(`OFF_D_NEXT, 32'hFFFF, 32'hFFFF, `RESP_OKAY);
      ld(16'h3F80, 16'h0000, 16'h0, 16'h0);
      go(OP_MOV, DT_F, 1'b0, 1'b1);
      res(16'h3F80, 16'h0000, 4'h0);
      ld(16'h8000, 16'h0000, 16'h0, 16'h0);
      go(OP_MOV, DT_F, 1'b0, 1'b1);
      res(16'h8000, 16'h0000, 4'h0);
      check({31'h0, carry_borrow_relay}, 32'h0);
      check({31'h0, exec_error_relay}, 32'h0);
      // Invalid patterns leave the destination as it was
      foreach (bad_fp[i])
      begin
         ld(bad_fp[i][31:16], bad_fp[i][15:0], 16'h0, 16'h0);
         go(OP_MOV, DT_F, 1'b0, 1'b1);
         res(16'h8000, 16'h0000, 4'h2);
         err_seen();
      end
      // Second register of the pair would cross an area end
      wr(`OFF_DST_IDX, 32'h0000_07CF, `RESP_OKAY);
      ld(16'h0001, 16'h0002, 16'h0, 16'h0);
      go(OP_MOV, DT_D, 1'b0, 1'b1);
      res(16'h8000, 16'h0000, 4'h2);
      err_seen();
      wr(`OFF_DST_IDX, 32'h0000_07CE, `RESP_OKAY);
      go(OP_MOV, DT_D, 1'b0, 1'b1);
      res(16'h0001, 16'h0002, 4'h0);
      check({31'h0, exec_error_relay}, 32'h0);
      // Unmapped place and read-only result
      rd(8'h24, 32'hFFFF_FFFF, 32'h0, `RESP_SLVERR);
      wr(8'h24, 32'h0000_1111, `RESP_SLVERR);
      wr(`OFF_D_FIRST, 32'h0000_5555, `RESP_OKAY);
      rd(`OFF_D_FIRST, 32'hFFFF, 32'h0001, `RESP_OKAY);
      tally_and_finish();
   end
endmodule : plc_operand_type_datapath_tb
